// [core/scc_core.sv]
// receive and transmit core of a serial channel: uart and i/o-interface modes
// assumes serialBaseClk is a one-cycle enable on clk_sys; pins are asynchronous
// Functional notes
// (RL1) framing error when first stop bit centre sample is 0; never in i/o mode
// (RL2) 4-bit receive counter on base clock; bit is majority of pulses 7, 8, 9
// (RL3) driven shift clock: sample receive pin on its rising edge
// (RL4) external shift clock: sample receive pin on the selected edge
// (RL5) uart receiver starts a frame only on a valid start bit
// (RL6) bits shift into receive register; receive interrupt at frame end
// (RL7) double buffer: frame moves to buffer, sets full flag; read clears it
// (RL8) driven clock receive halts when buffers full, restarts on read
// (RL9) parity bit or ninth bit stored into received ninth bit
// (RL10) 9-bit wake-up mode: interrupt only when received ninth bit is 1
// (RL11) over-run: set flag, keep buffer and ninth bit, drop shift register
// (RL12) 4-bit transmit counter gives a bit-clock pulse every 16th base clock
// (RL13) driven clock: transmit bit changes at falling edge of shift clock
// (RL14) external clock: transmit bit changes on the selected edge
// (RL15) uart frame starts on the next transmit bit-clock pulse after write
// (RL16) single buffer: write loads shifter; interrupt when frame ends (uart interrupts as the first stop bit starts)
// (RL17) double buffer: move to shifter sets empty flag, interrupts; write clears
// (RL18) driven clock transmit stops when nothing left, resumes on write
// (RL19) external clock: nothing loaded at next frame clock sets under-run flag
// (RL20) clear-to-send high holds next frame; interrupt timing unchanged
// (RL21) transmission resumes on first bit-clock edge after clear-to-send low
// (RL22) infrared output gates timer carrier with transmit data, unsynchronised
// (RL23) reading control register clears over-run, parity and framing flags
// (RL24) uart parity mismatch sets the parity flag
// (RL25) soft reset when soft reset field gets 10 then 01
// (RL26) clear-to-send and external clock are synchronised before use
//
// The placing of the registers and strobed register access were left to the implementer.
module scc_core (
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   input  wire scc_pkg::scc_bus_req_t busReq,
   output logic [31:0]               rdata,
   input  wire logic                 serialBaseClk,
   input  wire logic                 serialInPin,
   input  wire logic                 shiftClkIn,
   input  wire logic                 clearToSendIn,
   input  wire logic                 carrierIn,
   output logic                      serialOutPin,
   output logic                      shiftClkOut,
   output logic                      shiftClkOe,
   output logic                      receiveIntr,
   output logic                      transmitIntr,
   output logic                      infraredOut
);
   import scc_pkg::*;

   scc_state_t  st;
   scc_state_t  n;
   logic        bitClk;
   logic        extEdge;
   logic        newClk;
   logic        rxBitV;
   logic        frmDone;
   logic [7:0]  frmData;
   logic        frmNinth;
   logic [8:0]  word;
   logic [3:0]  nBits;
   logic [3:0]  stopIdx;
   logic [3:0]  frameLen;
   logic        rxHalt;
   logic        txDone;
   logic        rxDoneEv;
   logic        underEv;
   logic        softRst;
   logic        errSet;
   logic [31:0] rv;

   function automatic logic [11:0] frameOf(input logic [7:0] d, input logic u,
                                           input logic [1:0] ln, input logic pe,
                                           input logic po, input logic b9);
      logic [11:0] f;
      f = 12'hfff;
      if (!u) begin
         f[7:0] = d;
      end else begin
         f[0] = 1'b0;
         if (ln == LEN_7) begin
            f[7:1] = d[6:0];
            if (pe) f[8] = po ^ (^d[6:0]);
         end else begin
            f[8:1] = d;
            if (ln == LEN_9) f[9] = b9;
            else if (pe) f[9] = po ^ (^d);
         end
      end
      return f;
   endfunction

   always_comb begin
      n        = st;
      rv       = 32'h0;
      frmDone  = 1'b0;
      frmData  = 8'h0;
      frmNinth = 1'b0;
      word     = 9'h0;
      rxBitV   = 1'b0;
      txDone   = 1'b0;
      rxDoneEv = 1'b0;
      underEv  = 1'b0;
      softRst  = 1'b0;
      errSet   = 1'b0;
      n.rxIntr = 1'b0;
      n.txIntr = 1'b0;
      n.rdata  = 32'h0;
      // pin synchronisers: a change counts once stages two and three agree
      n.syncRx  = {st.syncRx[1:0], serialInPin};
      n.syncClk = {st.syncClk[1:0], shiftClkIn};
      n.syncCts = {st.syncCts[1:0], clearToSendIn};
      if (st.syncRx[1] == st.syncRx[2]) n.rxLvl = st.syncRx[2];
      if (st.syncCts[1] == st.syncCts[2]) n.ctsLvl = st.syncCts[2]; // RL26
      newClk   = (st.syncClk[1] == st.syncClk[2]) ? st.syncClk[2] : st.clkLvl; // RL26
      n.clkLvl = newClk;
      extEdge  = (newClk != st.clkLvl) && (newClk == ~st.clkEdge);
      nBits    = (st.len == LEN_9) ? 4'h9 : ((st.len == LEN_7) ? 4'h7 : 4'h8)
                 + {3'h0, st.parEn};
      stopIdx  = nBits + 4'h1;
      frameLen = stopIdx + 4'h1 + {3'h0, st.stopLen};
      rxHalt   = st.rxFull && (!st.dbuf || st.rxHeld);
      bitClk   = serialBaseClk && (st.txCnt == CNT_LAST);
      // register reads, answer in the following cycle
      if (busReq.rd) begin
         if (busReq.addr == ADDR_BUF) begin
            rv[7:0] = st.rxBuf;
            if (st.rxHeld) begin
               n.rxBuf  = st.rxShift[8:1];
               n.rxHeld = 1'b0;
               n.rxIntr = 1'b1;
            end else begin
               n.rxFull = 1'b0; // RL7
            end
         end else if (busReq.addr == ADDR_CR) begin
            rv[CR_DIR]  = st.clkDir;
            rv[CR_EDGE] = st.clkEdge;
            rv[CR_FERR] = st.ferr;
            rv[CR_PERR] = st.perr;
            rv[CR_OERR] = st.oerr;
            rv[CR_RB8]  = st.rb8;
            rv[CR_TB8]  = st.tb8;
            n.ferr = 1'b0; // RL23
            n.perr = 1'b0;
            n.oerr = 1'b0;
         end else if (busReq.addr == ADDR_MODE0) begin
            rv[M0_UART]            = st.uart;
            rv[M0_LEN+1:M0_LEN]    = st.len;
            rv[M0_WAKE]            = st.wake;
            rv[M0_HS]              = st.hsEn;
            rv[M0_RXEN]            = st.rxEn;
            rv[M0_TXEN]            = st.txEn;
            rv[M0_PAREN]           = st.parEn;
            rv[M0_PARODD]          = st.parOdd;
         end else if (busReq.addr == ADDR_MODE2) begin
            rv[M2_DBUF]   = st.dbuf;
            rv[M2_STOP]   = st.stopLen;
            rv[M2_RXFULL] = st.rxFull;
            rv[M2_TXEMP]  = st.txEmpty;
            rv[M2_TXRUN]  = st.txBusy;
         end
         n.rdata = rv;
      end
      // register writes
      if (busReq.wr) begin
         if (busReq.addr == ADDR_BUF) begin
            if (!st.dbuf) begin
               n.txShift  = frameOf(busReq.wdata[7:0], st.uart, st.len, st.parEn,
                                    st.parOdd, st.tb8); // RL16
               n.txLoaded = 1'b1;
            end else begin
               n.txBuf   = busReq.wdata[7:0];
               n.txEmpty = 1'b0; // RL17
               if (!st.txLoaded) begin
                  n.txShift  = frameOf(busReq.wdata[7:0], st.uart, st.len, st.parEn,
                                       st.parOdd, st.tb8);
                  n.txLoaded = 1'b1;
                  n.txEmpty  = 1'b1; // RL17
                  n.txIntr   = 1'b1;
               end
            end
         end else if (busReq.addr == ADDR_CR) begin
            n.clkDir  = busReq.wdata[CR_DIR];
            n.clkEdge = busReq.wdata[CR_EDGE];
            n.tb8     = busReq.wdata[CR_TB8];
         end else if (busReq.addr == ADDR_MODE0) begin
            n.uart   = busReq.wdata[M0_UART];
            n.len    = busReq.wdata[M0_LEN+1:M0_LEN];
            n.wake   = busReq.wdata[M0_WAKE];
            n.hsEn   = busReq.wdata[M0_HS];
            n.rxEn   = busReq.wdata[M0_RXEN];
            n.txEn   = busReq.wdata[M0_TXEN];
            n.parEn  = busReq.wdata[M0_PAREN];
            n.parOdd = busReq.wdata[M0_PARODD];
         end else if (busReq.addr == ADDR_MODE2) begin
            n.dbuf    = busReq.wdata[M2_DBUF];
            n.stopLen = busReq.wdata[M2_STOP];
            n.srPrev  = busReq.wdata[M2_SR+1:M2_SR];
            softRst   = (st.srPrev == SR_FIRST) && (busReq.wdata[M2_SR+1:M2_SR] == SR_SECOND);
         end
      end
      if (st.uart) begin
         // uart transmitter
         if (serialBaseClk) n.txCnt = st.txCnt + 4'h1; // RL12
         if (bitClk) begin
            if (st.txBusy) begin
               if (st.txBit == frameLen) begin
                  n.txBusy = 1'b0;
                  txDone   = 1'b1;
               end else begin
                  n.txd     = st.txShift[0];
                  n.txShift = {1'b1, st.txShift[11:1]};
                  n.txBit   = st.txBit + 4'h1;
                  if (st.txBit == stopIdx && !st.dbuf) n.txIntr = 1'b1; // RL16
               end
            end else if (st.txLoaded && st.txEn && !(st.hsEn && st.ctsLvl)) begin // RL20
               // bit clock pulse stands for its falling edge as well
               n.txBusy  = 1'b1; // RL15 RL21
               n.txBit   = 4'h1;
               n.txd     = st.txShift[0];
               n.txShift = {1'b1, st.txShift[11:1]};
            end
         end
         // uart receiver
         if (st.rxEn && serialBaseClk) begin
            if (!st.rxBusy) begin
               if (!st.rxLvl) begin
                  n.rxBusy = 1'b1;
                  n.rxCnt  = 4'h1;
                  n.rxBit  = 4'h0;
               end
            end else begin
               n.rxCnt = st.rxCnt + 4'h1; // RL2
               if (st.rxCnt == SAMPLE_A) n.votes[0] = st.rxLvl;
               if (st.rxCnt == SAMPLE_B) n.votes[1] = st.rxLvl;
               if (st.rxCnt == SAMPLE_C) begin
                  rxBitV  = (st.votes[0] & st.votes[1]) | (st.votes[0] & st.rxLvl)
                            | (st.votes[1] & st.rxLvl); // RL2
                  n.rxBit = st.rxBit + 4'h1;
                  if (st.rxBit == 4'h0) begin
                     if (rxBitV) n.rxBusy = 1'b0; // RL5
                  end else if (st.rxBit <= nBits) begin
                     n.rxShift = {rxBitV, st.rxShift[8:1]}; // RL6
                  end else begin
                     n.rxBusy = 1'b0;
                     word     = st.rxShift >> (RX_W - nBits);
                     frmDone  = 1'b1;
                     frmData  = (st.len == LEN_7) ? {1'b0, word[6:0]} : word[7:0];
                     frmNinth = (st.len == LEN_7) ? word[7] : word[8];
                     if (!rxBitV) begin
                        n.ferr = 1'b1; // RL1
                        errSet = 1'b1;
                     end
                     if (st.parEn && st.len != LEN_9 &&
                         (frmNinth != (st.parOdd ^ (^frmData)))) begin
                        n.perr = 1'b1; // RL24
                        errSet = 1'b1;
                     end
                  end
               end
            end
         end
      end else if (!st.clkDir) begin
         // i/o mode, shift clock driven here at half the base rate
         if (serialBaseClk) begin
            if (st.ioAct) begin
               n.sclk = ~st.sclk;
               if (st.sclk) begin
                  if (st.txBusy) begin
                     n.txd     = st.txShift[0]; // RL13
                     n.txShift = {1'b1, st.txShift[11:1]};
                  end
               end else begin
                  n.rxShift = {st.rxLvl, st.rxShift[8:1]}; // RL3
                  n.ioBit   = st.ioBit + 4'h1;
                  if (st.ioBit == IO_BITS - 4'h1) begin
                     n.ioAct = 1'b0;
                     txDone  = st.txBusy;
                     n.txBusy = 1'b0;
                     frmDone = st.rxEn;
                     frmData = n.rxShift[8:1];
                  end
               end
            end else if ((st.txEn && st.txLoaded) || (st.rxEn && !rxHalt)) begin // RL8 RL18
               n.ioAct  = 1'b1;
               n.ioBit  = 4'h0;
               n.txBusy = st.txEn && st.txLoaded;
            end
         end
      end else if (extEdge) begin
         // i/o mode, shift clock from the peer
         n.rxShift = {st.rxLvl, st.rxShift[8:1]}; // RL4
         n.txShift = {1'b1, st.txShift[11:1]}; // RL14
         n.ioBit   = st.ioBit + 4'h1;
         if (st.ioBit == 4'h0) begin
            n.txBusy = st.txLoaded;
            if (!st.txLoaded && st.txEn) begin
               n.perr  = 1'b1; // RL19
               errSet  = 1'b1;
               underEv = 1'b1;
               n.txShift = {4'hf, UNDER_FILL};
            end
         end
         if (st.ioBit == IO_BITS - 4'h1) begin
            n.ioBit  = 4'h0;
            txDone   = st.txBusy;
            n.txBusy = 1'b0;
            frmDone  = st.rxEn;
            frmData  = n.rxShift[8:1];
         end
      end
      // frame finished on the transmit side
      if (txDone) begin
         n.txLoaded = 1'b0;
         if (!st.uart && !st.dbuf) n.txIntr = 1'b1; // RL16
         if (st.dbuf && !n.txEmpty) begin
            n.txShift  = frameOf(n.txBuf, st.uart, st.len, st.parEn, st.parOdd, st.tb8);
            n.txLoaded = 1'b1;
            n.txEmpty  = 1'b1; // RL17
            n.txIntr   = 1'b1;
         end
      end
      // frame finished on the receive side
      if (frmDone) begin
         rxDoneEv = 1'b1;
         if (n.rxFull) begin
            if (!st.uart && !st.clkDir) begin
               n.rxHeld = 1'b1; // RL8
            end else begin
               n.oerr = 1'b1; // RL11
               errSet = 1'b1;
            end
         end else begin
            n.rxBuf  = frmData; // RL7
            n.rxFull = 1'b1;
            if (st.uart) n.rb8 = frmNinth; // RL9
            n.rxIntr = !(st.uart && st.len == LEN_9 && st.wake && !frmNinth); // RL6 RL10
         end
      end
      if (!st.uart && st.clkDir) n.txd = n.txShift[0]; // RL14
      if (softRst) begin
         n.rxEn     = 1'b0; // RL25
         n.txEn     = 1'b0;
         n.txEmpty  = TXEMP_RST;
         n.rxFull   = 1'b0;
         n.oerr     = 1'b0;
         n.perr     = 1'b0;
         n.rxBusy   = 1'b0;
         n.rxHeld   = 1'b0;
         n.txBusy   = 1'b0;
         n.txLoaded = 1'b0;
         n.ioAct    = 1'b0;
         n.ioBit    = 4'h0;
         n.txShift  = 12'hfff;
         n.txd      = 1'b1;
         n.sclk     = 1'b1;
         n.rxIntr   = 1'b0;
         n.txIntr   = 1'b0;
      end
      n.sclkOe = !n.uart && !n.clkDir;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st         <= '0;
         st.syncRx  <= 3'h7;
         st.rxLvl   <= 1'b1;
         st.syncClk <= 3'h7;
         st.clkLvl  <= 1'b1;
         st.txShift <= 12'hfff;
         st.txd     <= 1'b1;
         st.sclk    <= 1'b1;
         st.sclkOe  <= 1'b1;
         st.txEmpty <= TXEMP_RST;
      end else begin
         st <= n;
      end
   end

   assign rdata        = st.rdata;
   assign serialOutPin = st.txd;
   assign shiftClkOut  = st.sclk;
   assign shiftClkOe   = st.sclkOe;
   assign receiveIntr  = st.rxIntr;
   assign transmitIntr = st.txIntr;
   // carrier and data meet without resynchronisation, edges may be distorted
   assign infraredOut  = carrierIn & ~st.txd; // RL22

   a_ferr_uart_only: assert property (@(posedge clk_sys) disable iff (!resetn) // RL1
      $rose(st.ferr) |-> $past(st.uart)) else $error("framing flag set outside uart");
   a_full_on_frame: assert property (@(posedge clk_sys) disable iff (!resetn) // RL7
      $rose(st.rxFull) |-> $past(rxDoneEv)) else $error("full flag without frame");
   a_read_clears_full: assert property (@(posedge clk_sys) disable iff (!resetn) // RL7
      busReq.rd && busReq.addr == ADDR_BUF && !st.rxHeld && !rxDoneEv |=> !st.rxFull)
      else $error("buffer read left full flag");
   a_overrun_keeps: assert property (@(posedge clk_sys) disable iff (!resetn) // RL11
      rxDoneEv && st.rxFull && !busReq.rd && (st.uart || st.clkDir)
      |=> st.oerr && $stable(st.rxBuf) && $stable(st.rb8)) else $error("over-run mishandled");
   a_cr_read_clear: assert property (@(posedge clk_sys) disable iff (!resetn) // RL23
      busReq.rd && busReq.addr == ADDR_CR && !errSet |=> !st.ferr && !st.perr && !st.oerr)
      else $error("error flags survived read");
   a_wake_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // RL10
      st.rxIntr && $past(st.uart && st.len == LEN_9 && st.wake) |-> st.rb8)
      else $error("wake-up interrupt with ninth bit 0");
   a_empty_with_intr: assert property (@(posedge clk_sys) disable iff (!resetn) // RL17
      $rose(st.txEmpty) && !$past(softRst) |-> st.txIntr)
      else $error("empty flag without interrupt");
   a_underrun_flag: assert property (@(posedge clk_sys) disable iff (!resetn) // RL19
      underEv |=> st.perr [*1] ##1 1'b1) else $error("under-run not flagged");
   a_cts_holds: assert property (@(posedge clk_sys) disable iff (!resetn) // RL20
      st.uart && st.hsEn && st.ctsLvl && !st.txBusy && !softRst |=> !st.txBusy)
      else $error("frame started while clear-to-send high");
endmodule

// [core/scc_pkg.sv]
// constants, bus carrier and state record of the serial channel core
// assumes one system clock; the serial base clock arrives as a one-cycle enable
package scc_pkg;
   // register byte offsets
   localparam logic [3:0] ADDR_BUF   = 4'h0;
   localparam logic [3:0] ADDR_CR    = 4'h4;
   localparam logic [3:0] ADDR_MODE0 = 4'h8;
   localparam logic [3:0] ADDR_MODE2 = 4'hc;
   // mode_reg_zero fields
   localparam int M0_UART   = 0;
   localparam int M0_LEN    = 1;
   localparam int M0_WAKE   = 3;
   localparam int M0_HS     = 4;
   localparam int M0_RXEN   = 5;
   localparam int M0_TXEN   = 6;
   localparam int M0_PAREN  = 7;
   localparam int M0_PARODD = 8;
   // control_status_reg fields
   localparam int CR_DIR    = 0;
   localparam int CR_EDGE   = 1;
   localparam int CR_FERR   = 2;
   localparam int CR_PERR   = 3;
   localparam int CR_OERR   = 4;
   localparam int CR_RB8    = 5;
   localparam int CR_TB8    = 6;
   // mode_reg_two fields
   localparam int M2_DBUF   = 0;
   localparam int M2_STOP   = 1;
   localparam int M2_SR     = 2;
   localparam int M2_RXFULL = 4;
   localparam int M2_TXEMP  = 5;
   localparam int M2_TXRUN  = 6;
   // soft reset key sequence
   localparam logic [1:0] SR_FIRST  = 2'h2;
   localparam logic [1:0] SR_SECOND = 2'h1;
   // character lengths
   localparam logic [1:0] LEN_7 = 2'h0;
   localparam logic [1:0] LEN_8 = 2'h1;
   localparam logic [1:0] LEN_9 = 2'h2;
   // counts
   localparam logic [3:0] SAMPLE_A   = 4'h6;
   localparam logic [3:0] SAMPLE_B   = 4'h7;
   localparam logic [3:0] SAMPLE_C   = 4'h8;
   localparam logic [3:0] CNT_LAST   = 4'hf;
   localparam logic [3:0] IO_BITS    = 4'h8;
   localparam logic [3:0] RX_W       = 4'h9;
   localparam logic [7:0] UNDER_FILL = 8'hff;
   localparam logic       TXEMP_RST  = 1'b1;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } scc_bus_req_t;

   typedef struct packed {
      logic [2:0]  syncRx;
      logic [2:0]  syncClk;
      logic [2:0]  syncCts;
      logic        rxLvl;
      logic        clkLvl;
      logic        ctsLvl;
      logic        uart;
      logic [1:0]  len;
      logic        wake;
      logic        hsEn;
      logic        rxEn;
      logic        txEn;
      logic        parEn;
      logic        parOdd;
      logic        clkDir;
      logic        clkEdge;
      logic        tb8;
      logic        dbuf;
      logic        stopLen;
      logic [1:0]  srPrev;
      logic        ferr;
      logic        perr;
      logic        oerr;
      logic        rb8;
      logic        rxFull;
      logic        txEmpty;
      logic        rxBusy;
      logic [3:0]  rxCnt;
      logic [3:0]  rxBit;
      logic [1:0]  votes;
      logic [8:0]  rxShift;
      logic        rxHeld;
      logic [7:0]  rxBuf;
      logic [3:0]  txCnt;
      logic        txBusy;
      logic [3:0]  txBit;
      logic [11:0] txShift;
      logic        txLoaded;
      logic [7:0]  txBuf;
      logic        ioAct;
      logic [3:0]  ioBit;
      logic        txd;
      logic        sclk;
      logic        sclkOe;
      logic        rxIntr;
      logic        txIntr;
      logic [31:0] rdata;
   } scc_state_t;
endpackage

// [test/scc_peer.sv]
// serial peer: uart sender and receiver, i/o-interface clock master
// assumes clk is the core's system clock; one bit lasts 32 system clocks
module scc_peer (
   input  wire logic clk,
   input  wire logic txPin,
   input  wire logic sclkDrv,
   output logic      rxPin,
   output logic      sclk,
   output logic      cts
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rxPin = 1'b1;
      sclk  = 1'b1;
      cts   = 1'b0;
   end
   // frame bits go out lsb first, line pulled high afterwards
   task automatic send(input logic [10:0] f);
      for (int i = 0; i < 11; i++) begin
         rxPin <= f[i];
         repeat (32) @(posedge clk);
      end
      rxPin <= 1'b1;
   endtask
   task automatic recv(output logic [8:0] d);
      @(negedge txPin);
      repeat (16) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (32) @(posedge clk);
         d[i] = txPin;
      end
   endtask
   // 160 ns clock, data changed while low, core output taken before rise
   task automatic io(input logic [7:0] t, output logic [7:0] r);
      for (int i = 0; i < 8; i++) begin
         sclk  <= 1'b0;
         rxPin <= t[i];
         repeat (3) @(posedge clk);
         r[i] = txPin;
         @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
      end
      rxPin <= 1'b1;
   endtask
   // driven shift clock: core output taken at each rising edge
   task automatic take(output logic [7:0] r);
      for (int i = 0; i < 8; i++) begin
         @(posedge sclkDrv);
         r[i] = txPin;
      end
   endtask
endmodule

// [test/scc_core_tb.sv]
// self-checking bench of the serial channel core with a serial peer
// assumes register offsets of the package; base tick every other clock
module scc_core_tb;
   import scc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk_sys, resetn, serialBaseClk, carrierIn, peerRx, peerSclk, peerCts;
   logic         serialOutPin, shiftClkOut, shiftClkOe, receiveIntr, transmitIntr, infraredOut;
   logic [31:0]  rdata;
   logic [8:0]   got;
   scc_bus_req_t busReq;
   int           checks, failCount, rxSeen, txSeen, cycles;

   scc_core i_scc_core (.clk_sys(clk_sys), .resetn(resetn), .busReq(busReq), .rdata(rdata),
      .serialBaseClk(serialBaseClk), .serialInPin(peerRx),
      .shiftClkIn(shiftClkOe ? shiftClkOut : peerSclk), .clearToSendIn(peerCts),
      .carrierIn(carrierIn), .serialOutPin(serialOutPin), .shiftClkOut(shiftClkOut),
      .shiftClkOe(shiftClkOe), .receiveIntr(receiveIntr), .transmitIntr(transmitIntr),
      .infraredOut(infraredOut));
   scc_peer i_scc_peer (.clk(clk_sys), .txPin(serialOutPin), .sclkDrv(shiftClkOut),
      .rxPin(peerRx), .sclk(peerSclk), .cts(peerCts));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, failCount);
      if (failCount == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failCount++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      busReq.wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      busReq.rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk_sys);
      check(d & m, e);
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      serialBaseClk <= ~serialBaseClk;
      carrierIn     <= cycles[1];
      if (receiveIntr === 1'b1) rxSeen++;
      if (transmitIntr === 1'b1) txSeen++;
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         complete_run();
      end
   end
   always @(negedge clk_sys)
      if (resetn) check(infraredOut, carrierIn & ~serialOutPin);

   initial begin
      resetn = 1'b0;
      busReq = '0;
      serialBaseClk = 1'b0;
      carrierIn = 1'b0;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rdchk(ADDR_MODE2, 32'hffffffff, 32'h20);
      rdchk(4'h1, 32'hffffffff, 32'h0);
      // 8-bit even parity receive, then errors and over-run
      wr(ADDR_MODE0, 32'ha3);
      i_scc_peer.send({1'b1, 1'b0, 8'h5a, 1'b0});
      check(rxSeen, 1);
      rdchk(ADDR_MODE2, 32'h30, 32'h30);
      rdchk(ADDR_BUF, 32'hff, 32'h5a);
      rdchk(ADDR_MODE2, 32'h10, 32'h0);
      i_scc_peer.send({1'b0, 1'b1, 8'ha5, 1'b0});
      rdchk(ADDR_CR, 32'h3c, 32'h2c);
      rdchk(ADDR_CR, 32'h3c, 32'h20);
      i_scc_peer.send({1'b1, 1'b0, 8'h3c, 1'b0});
      check(rxSeen, 2);
      rdchk(ADDR_CR, 32'h3c, 32'h30);
      rdchk(ADDR_BUF, 32'hff, 32'ha5);
      // 9-bit wake-up: only a set ninth bit interrupts
      wr(ADDR_MODE0, 32'h2d);
      i_scc_peer.send({1'b1, 1'b0, 8'h11, 1'b0});
      check(rxSeen, 2);
      rdchk(ADDR_BUF, 32'hff, 32'h11);
      i_scc_peer.send({1'b1, 1'b1, 8'h22, 1'b0});
      check(rxSeen, 3);
      rdchk(ADDR_CR, 32'h20, 32'h20);
      rdchk(ADDR_BUF, 32'hff, 32'h22);
      // transmit held by clear-to-send, then sent
      wr(ADDR_MODE0, 32'h53);
      i_scc_peer.cts <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wr(ADDR_BUF, 32'hc3);
      repeat (96) @(posedge clk_sys);
      check(serialOutPin, 1'b1);
      i_scc_peer.cts <= 1'b0;
      i_scc_peer.recv(got);
      check(got, {1'b1, 8'hc3});
      check(txSeen, 1);
      repeat (32) @(posedge clk_sys);
      // external shift clock on rising edges, then an under-run frame
      wr(ADDR_CR, 32'h1);
      wr(ADDR_MODE0, 32'h60);
      wr(ADDR_BUF, 32'ha5);
      i_scc_peer.io(8'h3c, got[7:0]);
      check(got[7:0], 8'ha5);
      repeat (8) @(posedge clk_sys);
      check(rxSeen, 4);
      rdchk(ADDR_BUF, 32'hff, 32'h3c);
      i_scc_peer.io(8'h00, got[7:0]);
      check(got[7:0], 8'hff);
      repeat (8) @(posedge clk_sys);
      rdchk(ADDR_CR, 32'h8, 32'h8);
      // soft reset key pair
      wr(ADDR_MODE2, 32'h8);
      wr(ADDR_MODE2, 32'h4);
      rdchk(ADDR_MODE0, 32'h60, 32'h0);
      rdchk(ADDR_MODE2, 32'h30, 32'h20);
      // driven shift clock: receive halts on a full single buffer until read
      wr(ADDR_CR, 32'h0);
      wr(ADDR_BUF, 32'h96);
      wr(ADDR_MODE0, 32'h60);
      i_scc_peer.take(got[7:0]);
      check(got[7:0], 8'h96);
      repeat (40) @(posedge clk_sys);
      check(rxSeen, 6);
      check(txSeen, 3);
      rdchk(ADDR_BUF, 32'hff, 32'hff);
      repeat (40) @(posedge clk_sys);
      check(rxSeen, 7);
      // uart double buffer: move sets empty flag, next write clears it
      wr(ADDR_MODE0, 32'h43);
      wr(ADDR_MODE2, 32'h1);
      wr(ADDR_BUF, 32'h11);
      wr(ADDR_BUF, 32'h22);
      check(txSeen, 4);
      rdchk(ADDR_MODE2, 32'h20, 32'h0);
      repeat (400) @(posedge clk_sys);
      rdchk(ADDR_MODE2, 32'h20, 32'h20);
      check(txSeen, 5);
      complete_run();
   end
endmodule
